// File: src/drf_pkg.sv
package drf_pkg;
  // bus commands, active-low byte enables follow the bus convention
  localparam logic [3:0] CMD_IO_RD = 4'h2;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_CFG_RD = 4'hA;
  localparam logic [3:0] CMD_MEM_RD_MULT = 4'hC;
  localparam logic [3:0] CMD_MEM_RD_LINE = 4'hE;
  localparam logic [3:0] BE_ALL_ON = 4'h0;

  localparam int QDEPTH = 3;
  localparam logic [31:0] DW_BYTES = 32'h0000_0004;
  localparam logic [31:0] BND_16DW = 32'h0000_0040;
  localparam logic [31:0] BND_4K = 32'h0000_1000;
  localparam logic [7:0] CLS_MAX = 8'h40;

  localparam int RETRY_LIMIT_DEF = 16777216;
  localparam int DISCARD_LONG_DEF = 32768;
  localparam int DISCARD_SHORT_DEF = 1024;

  localparam logic [11:0] APB_CTRL = 12'h000;
  localparam logic [11:0] APB_STAT = 12'h004;
  localparam int CTRL_CLS_LSB = 0;
  localparam int CTRL_SERR_BIT = 8;
  localparam int CTRL_SHORT_BIT = 9;
  localparam int STAT_QCNT_LSB = 8;
  localparam int STAT_ENG_LSB = 12;
  localparam int STAT_FLOW_BIT = 20;
  localparam int STAT_DRAIN_BIT = 21;
  localparam logic [7:0] CLS_RST = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_FETCH = 4'h2,
    ST_DONE = 4'h4,
    ST_ABORT = 4'h8
  } eng_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [3:0] cmd;
    logic par;
    logic [3:0] be;
    logic pref;
  } rd_req_t;

  typedef struct packed {
    logic frame;
    logic [31:0] addr;
    logic [3:0] cmd;
    logic [3:0] be;
  } tgt_req_t;

  typedef struct packed {
    logic ack;
    logic retry;
    logic disc;
    logic err;
    logic [31:0] data;
  } tgt_rsp_t;

  typedef struct packed {
    logic retry;
    logic abort;
    logic trdy;
    logic stop;
    logic [31:0] data;
  } init_rsp_t;
endpackage

// File: src/delayed_read_forwarding.sv
// Behaviour
// RULE1 - stop prefetching at the aligned boundary unless the target disconnects first
// RULE2 - disconnect on the last prefetched dword; drop leftover prefetched data
// RULE3 - flow-through prefetchable reads run to the 4 KB boundary or initiator end
// RULE4 - config, I/O and non-prefetchable memory reads fetch one dword only
// RULE5 - memory read and read line stop at cacheline, else 16-dword boundary
// RULE6 - read multiple stops at second cacheline, else when the queue fills
// RULE7 - capture address, command, parity; byte enables at irdy; then queue it
// RULE8 - first attempt of a delayed read always ends in retry, no data
// RULE9 - initiator repeats the identical read until data or abort
// RULE10 - start target read only at queue head with posted writes drained
// RULE11 - captured enables on first phase; prefetch later phases all bytes on
// RULE12 - reissue on target retry; no new attempt after data then termination
// RULE13 - after retry limit with no data: abort, drop entry, raise system error
// RULE14 - accept one dword per clock from target into the read data queue
// RULE15 - repeat at queue head gets data; the three memory reads alias
// RULE16 - disconnect with final dword; discard rest if initiator stops early
// RULE17 - draining during a running prefetch read switches to flow-through
// RULE18 - flow-through ends at initiator stop, 4 KB or full; stall on empty
// RULE19 - initiator end in flow-through ends target frame and flushes data
// RULE20 - discard timer at head, two loads; expiry drops entry and data
// RULE21 - at most three delayed reads queued
// RULE22 - a matching read already queued creates no new entry
//
// Added by the designer: the APB slave port and the placing of the registers.
module delayed_read_forwarding
  import drf_pkg::*;
#(
  parameter int RDQ_DEPTH = 8,
  parameter int RETRY_LIMIT = RETRY_LIMIT_DEF,
  parameter int DISCARD_LONG = DISCARD_LONG_DEF,
  parameter int DISCARD_SHORT = DISCARD_SHORT_DEF
) (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic INIT_START,
  input wire rd_req_t INIT_REQ,
  input wire logic INIT_IRDY,
  input wire logic INIT_END,
  output init_rsp_t INIT_RSP,
  input wire logic PW_PENDING,
  output tgt_req_t TGT_REQ,
  input wire tgt_rsp_t TGT_RSP,
  output logic PRIMARY_SYSTEM_ERROR_OUT
);
  localparam int AW = $clog2(RDQ_DEPTH);
  localparam int CW = AW + 1;

  if (RDQ_DEPTH < 2 || (RDQ_DEPTH & (RDQ_DEPTH - 1)) != 0 || RETRY_LIMIT < 2 ||
      RETRY_LIMIT > 33554431 || DISCARD_LONG < 2 || DISCARD_LONG > 65535 ||
      DISCARD_SHORT < 2 || DISCARD_SHORT > 65535) begin : g_bad_param
    $error("delayed_read_forwarding: unsupported parameter value");
  end

  typedef struct packed {
    eng_t eng;
    rd_req_t [QDEPTH-1:0] q;
    logic [1:0] qcnt;
    rd_req_t cap;
    logic cap_pend;
    logic [RDQ_DEPTH-1:0][31:0] buff;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
    logic [31:0] fa;
    logic [31:0] lim;
    logic got;
    logic flow;
    logic drain;
    logic [24:0] rcnt;
    logic [15:0] dcnt;
    tgt_req_t tgt;
    init_rsp_t rsp;
    logic serr;
    logic [7:0] cache_line_size_setting;
    logic serr_en;
    logic short_sel;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_t;

  state_t s;
  state_t next_s;
  logic [QDEPTH-1:0] hit;
  logic head_hit;

  function automatic logic is_mem(input logic [3:0] c);
    return c == CMD_MEM_RD || c == CMD_MEM_RD_LINE || c == CMD_MEM_RD_MULT;
  endfunction

  function automatic logic cmd_eq(input logic [3:0] a, input logic [3:0] b);
    return (is_mem(a) && is_mem(b)) || a == b;
  endfunction

  function automatic logic [31:0] fetch_limit(input rd_req_t r, input logic [7:0] cache_line_size_setting,
                                              input logic flow);
    logic [31:0] line;
    logic [31:0] base;
    logic ok;
    line = {22'h0, cache_line_size_setting, 2'b00};
    base = {r.addr[31:2], 2'b00};
    ok = cache_line_size_setting != 8'h00 && (cache_line_size_setting & (cache_line_size_setting - 8'h01)) == 8'h00 && cache_line_size_setting <= CLS_MAX;
    if (!r.pref) return base + DW_BYTES; // RULE4
    if (flow || (r.cmd == CMD_MEM_RD_MULT && !ok)) return (base & ~(BND_4K - 32'h1)) + BND_4K; // RULE3 RULE6
    if (!ok) return (base & ~(BND_16DW - 32'h1)) + BND_16DW; // RULE5
    if (r.cmd == CMD_MEM_RD_MULT) return (base & ~(line - 32'h1)) + (line << 1); // RULE6
    return (base & ~(line - 32'h1)) + line; // RULE5
  endfunction

  for (genvar i = 0; i < QDEPTH; i++) begin : g_match
    assign hit[i] = 2'(i) < s.qcnt && s.q[i].addr == s.cap.addr &&
                    cmd_eq(s.q[i].cmd, s.cap.cmd); // RULE15 RULE22
  end
  assign head_hit = hit[0];

  always_comb begin
    logic take;
    logic put;
    logic qpop;
    logic enq;
    logic [CW-1:0] cnt_after;
    take = 1'b0;
    put = 1'b0;
    qpop = 1'b0;
    enq = 1'b0;
    cnt_after = '0;
    next_s = s;
    next_s.rsp = '0;
    next_s.serr = 1'b0;

    // register slave: ready one cycle into the access phase, write lands on completion
    next_s.pready = PSEL && PENABLE && !s.pready;
    if (PSEL && PENABLE && !s.pready) begin
      next_s.pslverr = 1'b0;
      next_s.prdata = '0;
      case (PADDR)
        APB_CTRL: begin
          next_s.prdata[CTRL_CLS_LSB +: 8] = s.cache_line_size_setting;
          next_s.prdata[CTRL_SERR_BIT] = s.serr_en;
          next_s.prdata[CTRL_SHORT_BIT] = s.short_sel;
        end
        APB_STAT: begin
          next_s.prdata = 32'(s.cnt) | (32'(s.qcnt) << STAT_QCNT_LSB) |
                          (32'(s.eng) << STAT_ENG_LSB);
          next_s.prdata[STAT_FLOW_BIT] = s.flow;
          next_s.prdata[STAT_DRAIN_BIT] = s.drain;
        end
        default: next_s.pslverr = 1'b1;
      endcase
    end
    if (PSEL && PENABLE && s.pready && PWRITE && PADDR == APB_CTRL) begin
      next_s.cache_line_size_setting = PWDATA[CTRL_CLS_LSB +: 8];
      next_s.serr_en = PWDATA[CTRL_SERR_BIT];
      next_s.short_sel = PWDATA[CTRL_SHORT_BIT];
    end

    // attempt from the initiator: address phase, then enables when irdy shows
    if (INIT_START && !s.cap_pend && !s.drain) begin
      next_s.cap = INIT_REQ; // RULE7
      next_s.cap.pref = INIT_REQ.cmd == CMD_MEM_RD_LINE || INIT_REQ.cmd == CMD_MEM_RD_MULT ||
                        (INIT_REQ.cmd == CMD_MEM_RD && INIT_REQ.pref);
      next_s.cap_pend = 1'b1;
    end
    if (s.cap_pend && INIT_IRDY) begin
      next_s.cap_pend = 1'b0;
      if (head_hit && s.eng == ST_ABORT) begin
        next_s.rsp.abort = 1'b1; // RULE13
        qpop = 1'b1;
      end else if (head_hit && s.eng == ST_DONE) begin
        next_s.drain = 1'b1; // RULE15
      end else if (head_hit && s.eng == ST_FETCH && s.q[0].pref && s.cnt != '0) begin
        next_s.drain = 1'b1; // RULE17
        next_s.flow = 1'b1;
        next_s.lim = fetch_limit(s.q[0], s.cache_line_size_setting, 1'b1); // RULE18
      end else begin
        next_s.rsp.retry = 1'b1; // RULE8
        enq = hit == '0 && s.qcnt < 2'(QDEPTH); // RULE21 RULE22
      end
    end

    // hand buffered data to the repeating initiator
    if (s.drain) begin
      if (INIT_END) begin
        qpop = 1'b1; // RULE16 RULE19
      end else if (INIT_IRDY && s.cnt != '0) begin
        take = 1'b1; // RULE18
        next_s.rsp.trdy = 1'b1;
        next_s.rsp.data = s.buff[s.rp];
        if (s.cnt == CW'(1) && s.eng == ST_DONE) begin
          next_s.rsp.stop = 1'b1; // RULE2 RULE16
          qpop = 1'b1;
        end
      end
    end

    case (s.eng)
      ST_IDLE: begin
        if (s.qcnt != '0 && !PW_PENDING && !qpop) begin
          next_s.eng = ST_FETCH; // RULE10
          next_s.tgt.frame = 1'b1;
          next_s.tgt.addr = s.q[0].addr;
          next_s.tgt.cmd = s.q[0].cmd;
          next_s.tgt.be = s.q[0].be; // RULE11
          next_s.fa = {s.q[0].addr[31:2], 2'b00};
          next_s.lim = fetch_limit(s.q[0], s.cache_line_size_setting, 1'b0);
          next_s.got = 1'b0;
        end
      end
      ST_FETCH: begin
        if (TGT_RSP.ack) begin
          put = 1'b1; // RULE14
          next_s.got = 1'b1;
          next_s.fa = s.fa + DW_BYTES;
          if (s.q[0].pref) next_s.tgt.be = BE_ALL_ON; // RULE11
          cnt_after = s.cnt + CW'(1) - CW'(take);
          // a disconnect with data ends the burst before the boundary
          if (next_s.fa == next_s.lim || TGT_RSP.disc || cnt_after == CW'(RDQ_DEPTH)) begin
            next_s.tgt.frame = 1'b0; // RULE1 RULE18
            next_s.eng = ST_DONE;
          end
        end else if (TGT_RSP.retry || TGT_RSP.disc || TGT_RSP.err) begin
          next_s.tgt.frame = 1'b0;
          if (s.got) begin
            next_s.eng = ST_DONE; // RULE12
          end else if (TGT_RSP.err || s.rcnt == 25'(RETRY_LIMIT - 1)) begin
            next_s.eng = ST_ABORT; // RULE13
            next_s.serr = s.serr_en;
          end else begin
            next_s.eng = ST_IDLE; // RULE12
            next_s.rcnt = s.rcnt + 25'h1;
          end
        end
        next_s.dcnt = s.short_sel ? 16'(DISCARD_SHORT) : 16'(DISCARD_LONG); // RULE20
      end
      ST_DONE: begin
        // timer runs only while nobody is draining the completion
        if (!s.drain && !next_s.drain) begin
          if (s.dcnt == 16'h1) begin
            qpop = 1'b1; // RULE20
            next_s.serr = s.serr_en;
          end else begin
            next_s.dcnt = s.dcnt - 16'h1;
          end
        end
      end
      ST_ABORT: begin
      end
      default: next_s.eng = ST_IDLE;
    endcase

    if (take) next_s.rp = s.rp + 1'b1;
    if (put) begin
      next_s.buff[s.wp] = TGT_RSP.data;
      next_s.wp = s.wp + 1'b1;
    end
    next_s.cnt = s.cnt + CW'(put) - CW'(take);

    // retiring the head drops its leftover data and any burst still running
    if (qpop) begin
      next_s.q[0] = s.q[1];
      next_s.q[1] = s.q[2];
      next_s.qcnt = s.qcnt - 2'h1;
      next_s.eng = ST_IDLE;
      next_s.drain = 1'b0;
      next_s.flow = 1'b0;
      next_s.rcnt = '0;
      next_s.tgt.frame = 1'b0; // RULE19
      next_s.wp = '0; // RULE2 RULE16
      next_s.rp = '0;
      next_s.cnt = '0;
    end
    if (enq) begin
      next_s.q[next_s.qcnt] = s.cap; // RULE7
      next_s.q[next_s.qcnt].be = INIT_REQ.be;
      next_s.qcnt = next_s.qcnt + 2'h1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      s <= '0;
      s.eng <= ST_IDLE;
      s.cache_line_size_setting <= CLS_RST;
    end else begin
      s <= next_s;
    end
  end

  assign PRDATA = s.prdata;
  assign PREADY = s.pready;
  assign PSLVERR = s.pslverr;
  assign INIT_RSP = s.rsp;
  assign TGT_REQ = s.tgt;
  assign PRIMARY_SYSTEM_ERROR_OUT = s.serr;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  chk_first_retry: assert property (s.cap_pend && INIT_IRDY && hit == '0 && !s.drain // RULE8
      |=> s.rsp.retry && !s.rsp.trdy) else $error("new read not retried");
  chk_queue_bound: assert property (s.qcnt <= 2'(QDEPTH)) // RULE21
    else $error("queue holds more than three");
  chk_dup_entry: assert property (s.cap_pend && INIT_IRDY && hit != '0 // RULE22
      |=> s.qcnt <= $past(s.qcnt)) else $error("duplicate read queued");
  chk_issue_order: assert property ($rose(s.tgt.frame) // RULE10
      |-> !$past(PW_PENDING) && s.tgt.addr == $past(s.q[0].addr)) else $error("bad issue");
  chk_later_be: assert property (s.tgt.frame && s.got && s.q[0].pref // RULE11
      |-> s.tgt.be == BE_ALL_ON) else $error("later phase enables not all on");
  chk_boundary: assert property (s.tgt.frame |-> s.fa != s.lim) // RULE1
    else $error("prefetch ran past boundary");
  chk_nowait: assert property (s.eng == ST_FETCH && TGT_RSP.ack // RULE14
      |=> s.fa == $past(s.fa) + DW_BYTES && s.got) else $error("dword not accepted");
  chk_last_stop: assert property (s.rsp.stop |-> s.rsp.trdy && s.cnt == '0 && !s.drain) // RULE16
    else $error("stop without final dword");
  chk_flow_trdy: assert property (s.drain && INIT_IRDY && !INIT_END && s.cnt != '0 // RULE18
      |=> s.rsp.trdy) else $error("wait state with data buffered");
  chk_end_flush: assert property (s.drain && INIT_END // RULE19
      |=> !s.tgt.frame && s.cnt == '0 && !s.drain) else $error("initiator end not forwarded");
  chk_abort_serr: assert property (s.eng == ST_FETCH && !s.got && TGT_RSP.err // RULE13
      |=> s.eng == ST_ABORT && s.serr == $past(s.serr_en)) else $error("abort not raised");
  chk_single_dword: assert property (s.eng == ST_FETCH && !s.q[0].pref && TGT_RSP.ack // RULE4
      |=> !s.tgt.frame) else $error("non-prefetch read fetched more than one dword");
  chk_line_stop: assert property (s.eng == ST_FETCH && !s.flow && s.q[0].pref && // RULE5
      s.q[0].cmd != CMD_MEM_RD_MULT && TGT_RSP.ack && !(s.cap_pend && INIT_IRDY) &&
      ((s.fa + DW_BYTES) & (32'({CLS_MAX, 2'b00}) - 32'h1)) == 32'h0 |=> !s.tgt.frame)
    else $error("line read ran past its boundary");
  chk_full_stop: assert property (s.eng == ST_FETCH && TGT_RSP.ack && !s.drain && // RULE6
      s.cnt == CW'(RDQ_DEPTH - 1) |=> !s.tgt.frame && s.eng == ST_DONE)
    else $error("fetch ran on with the buffer full");
  chk_flow_bound: assert property (s.flow && s.tgt.frame // RULE3
      |-> (s.lim & (BND_4K - 32'h1)) == 32'h0) else $error("flow limit not on a 4 KB boundary");
  chk_capture: assert property (INIT_START && !s.cap_pend && !s.drain // RULE7
      |=> s.cap_pend && s.cap.addr == $past(INIT_REQ.addr) &&
      s.cap.cmd == $past(INIT_REQ.cmd) && s.cap.par == $past(INIT_REQ.par))
    else $error("address phase not captured");
  chk_enqueue_be: assert property (s.cap_pend && INIT_IRDY && s.qcnt == 2'h0 // RULE7
      |=> s.qcnt == 2'h1 && s.q[0].be == $past(INIT_REQ.be) && s.q[0].addr == $past(s.cap.addr))
    else $error("request not queued with its enables");
  chk_issue_fields: assert property ($rose(s.tgt.frame) // RULE10 RULE11
      |-> s.tgt.cmd == $past(s.q[0].cmd) && s.tgt.be == $past(s.q[0].be))
    else $error("issued command or enables differ from the queue");
  chk_no_reissue: assert property (s.eng == ST_FETCH && s.got && !TGT_RSP.ack && // RULE12
      !s.drain && (TGT_RSP.retry || TGT_RSP.disc) |=> s.eng == ST_DONE && !s.tgt.frame)
    else $error("new attempt after data");
  chk_retry_count: assert property (s.eng == ST_FETCH && !s.got && TGT_RSP.retry && // RULE12
      !TGT_RSP.ack && !TGT_RSP.err && s.rcnt != 25'(RETRY_LIMIT - 1)
      |=> s.eng == ST_IDLE && s.rcnt == $past(s.rcnt) + 25'h1) else $error("retry not reissued");
  chk_limit_abort: assert property (s.eng == ST_FETCH && !s.got && TGT_RSP.retry && // RULE13
      !TGT_RSP.ack && s.rcnt == 25'(RETRY_LIMIT - 1)
      |=> s.eng == ST_ABORT && s.serr == $past(s.serr_en)) else $error("retry limit missed");
  chk_abort_reply: assert property (s.cap_pend && INIT_IRDY && head_hit && // RULE13
      s.eng == ST_ABORT |=> s.rsp.abort && s.eng == ST_IDLE && s.qcnt == $past(s.qcnt) - 2'h1)
    else $error("abort not returned");
  chk_repeat_drain: assert property (s.cap_pend && INIT_IRDY && head_hit && s.eng == ST_DONE // RULE15
      |=> s.drain && !s.rsp.retry) else $error("completed read not handed over");
  chk_flow_switch: assert property (s.cap_pend && INIT_IRDY && head_hit && // RULE17
      s.eng == ST_FETCH && s.q[0].pref && s.cnt != '0 |=> s.drain && s.flow)
    else $error("flow-through not entered");
  chk_final_stop: assert property (s.drain && !INIT_END && INIT_IRDY && s.cnt == CW'(1) && // RULE16
      s.eng == ST_DONE |=> s.rsp.stop && s.qcnt == $past(s.qcnt) - 2'h1)
    else $error("last dword without disconnect");
  chk_empty_stall: assert property (s.drain && s.cnt == '0 |=> !s.rsp.trdy) // RULE18
    else $error("ready given with the buffer empty");
  chk_discard_load: assert property (s.eng == ST_FETCH // RULE20
      |=> s.dcnt == ($past(s.short_sel) ? 16'(DISCARD_SHORT) : 16'(DISCARD_LONG)))
    else $error("discard timer not loaded");
  chk_discard_fire: assert property (s.eng == ST_DONE && !s.drain && // RULE20
      !(s.cap_pend && INIT_IRDY) && s.dcnt == 16'h1
      |=> s.eng == ST_IDLE && s.serr == $past(s.serr_en)) else $error("discard not done");
endmodule

// File: dv/pci_target_model.sv
module pci_target_model
  import drf_pkg::*;
#(
  parameter logic [31:0] PAT = 32'h5A5A_0000
) (
  input wire logic clk,
  input wire logic nrst,
  input wire tgt_req_t req,
  input wire logic [31:0] retries,
  input wire logic slow,
  output tgt_rsp_t rsp
);
  logic [31:0] tries;
  logic [7:0] cnt;
  logic tgl;
  logic [31:0] fa;
  assign fa = req.addr + {22'h0, cnt, 2'b00};
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tries <= 32'h0;
      cnt <= 8'h0;
      tgl <= 1'b0;
    end else begin
      tgl <= ~tgl;
      cnt <= req.frame ? cnt + {7'h0, rsp.ack} : 8'h0;
      // a delivered dword closes the retry series of that read
      if (rsp.ack) begin
        tries <= 32'h0;
      end else if (rsp.retry) begin
        tries <= tries + 32'h1;
      end
    end
  end
  // acks only while the frame stands; an idle bus never shows a stale dword
  always_comb begin
    rsp = '0;
    rsp.data = ~(fa ^ PAT);
    if (req.frame && cnt == 8'h0 && tries < retries) begin
      rsp.retry = 1'b1;
    end else if (req.frame && (!slow || tgl)) begin
      rsp.ack = 1'b1;
      rsp.data = fa ^ PAT;
    end
  end
endmodule

// File: dv/tb_top.sv
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_top
  import drf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] PAT = 32'h5A5A_0000;
  logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, retries = '0;
  logic start = 0, irdy = 0, endp = 0, pw = 0, slow = 0, serr, fr_q = 0, ack_q = 0;
  logic cur_pref = 0;
  logic [3:0] be_r = '0, be_first = '0;
  rd_req_t req = '0;
  init_rsp_t rsp;
  tgt_req_t treq;
  tgt_rsp_t trsp;
  int fail_count = 0, comparisons = 0, frames = 0, acks = 0, serr_cnt = 0, be_bad = 0;
  always #5 clk = ~clk;
  delayed_read_forwarding #(.RDQ_DEPTH(8), .RETRY_LIMIT(4), .DISCARD_LONG(200),
    .DISCARD_SHORT(8)) dut (.SYS_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .INIT_START(start), .INIT_REQ(req), .INIT_IRDY(irdy),
    .INIT_END(endp), .INIT_RSP(rsp), .PW_PENDING(pw), .TGT_REQ(treq), .TGT_RSP(trsp),
    .PRIMARY_SYSTEM_ERROR_OUT(serr));
  pci_target_model #(.PAT(PAT)) target (.clk(clk), .nrst(nrst), .req(treq),
    .retries(retries), .slow(slow), .rsp(trsp));
  always @(posedge clk) begin
    if (treq.frame && !fr_q) begin
      frames++;
      be_first = treq.be;
    end
    if (treq.frame && ack_q && cur_pref && treq.be !== BE_ALL_ON) be_bad++;
    if (trsp.ack === 1'b1 && treq.frame) acks++;
    if (serr === 1'b1) serr_cnt++;
    fr_q = treq.frame;
    ack_q = trsp.ack & treq.frame;
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic rst();
    @(posedge clk);
    nrst <= 0;
    repeat (16) @(posedge clk);
    nrst <= 1;
    repeat (2) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // kind: 0 retry, 1 abort, 2 data, 3 no answer
  task automatic ask(input logic [31:0] a, input logic [3:0] c, input logic p, output int k);
    int n;
    @(posedge clk);
    start <= 1;
    req <= '{addr: a, cmd: c, par: ^{a, c}, be: be_r, pref: p};
    @(posedge clk);
    start <= 0;
    irdy <= 1;
    k = 3;
    for (n = 0; n < 20 && k == 3; n++) begin
      @(negedge clk);
      if (rsp.retry === 1'b1) k = 0;
      else if (rsp.abort === 1'b1) k = 1;
      else if (rsp.trdy === 1'b1) k = 2;
    end
  endtask
  task automatic get(input logic [31:0] a, input logic [3:0] c, input logic p, input int lim,
                     output int got, output logic stp);
    int k, i;
    got = 0;
    stp = 0;
    for (i = 0; i < 60; i++) begin
      ask(a, c, p, k);
      if (k != 0) break;
      @(posedge clk);
      irdy <= 0;
      repeat (3) @(posedge clk);
    end
    for (i = 0; i < 300 && k == 2; i++) begin
      if (rsp.trdy === 1'b1) begin
        `CHK(rsp.data, (a + 32'(4 * got)) ^ PAT)
        got++;
        stp = rsp.stop;
      end
      if (stp === 1'b1 || got >= lim) break;
      @(negedge clk);
    end
    @(posedge clk);
    irdy <= 0;
    endp <= (k == 2);
    @(posedge clk);
    endp <= 0;
  endtask
  task automatic one(input logic [7:0] cache_line_size_setting, input logic [31:0] a, input logic [3:0] c,
                     input logic [3:0] c2, input logic p, input logic [3:0] b, input int r,
                     input int n);
    int k, f0, a0, got;
    logic stp, e;
    logic [31:0] q;
    apb(1'b1, APB_CTRL, {23'h0, 1'b1, cache_line_size_setting}, q, e);
    retries <= 32'(r);
    be_r <= b;
    cur_pref = p;
    be_bad = 0;
    f0 = frames;
    a0 = acks;
    ask(a, c, p, k);
    `CHK(k, 0)
    @(posedge clk);
    irdy <= 0;
    repeat (60) @(posedge clk);
    `CHK(frames - f0, r + 1)
    `CHK(acks - a0, n)
    `CHK(be_first, b)
    `CHK(be_bad, 0)
    get(a, c2, p, 64, got, stp);
    `CHK(got, n)
    `CHK(stp, 1'b1)
    `CHK(frames - f0, r + 1)
    $display("read %h done", a);
  endtask
  task automatic flow(input logic [31:0] a, input int lim, input int n);
    int k, got;
    logic stp, e;
    logic [31:0] q;
    apb(1'b1, APB_CTRL, 32'h0000_0103, q, e);
    slow <= 1;
    retries <= 0;
    ask(a, CMD_MEM_RD_MULT, 1'b1, k);
    @(posedge clk);
    irdy <= 0;
    get(a, CMD_MEM_RD_MULT, 1'b1, lim, got, stp);
    repeat (3) @(posedge clk);
    `CHK(treq.frame, 1'b0)
    `CHK(got, n)
    slow <= 0;
    repeat (20) @(posedge clk);
    $display("flow %h done", a);
  endtask
  task automatic misc();
    int k, s0, f0, got, i;
    logic stp, e;
    logic [31:0] q;
    apb(1'b1, APB_CTRL, 32'h0000_0308, q, e);
    apb(1'b0, APB_CTRL, 32'h0, q, e);
    `CHK(q, 32'h0000_0308)
    apb(1'b0, 12'h010, 32'h0, q, e);
    `CHK(e, 1'b1)
    s0 = serr_cnt;
    f0 = frames;
    ask(32'h0000_8000, CMD_IO_RD, 1'b0, k);
    @(posedge clk);
    irdy <= 0;
    repeat (60) @(posedge clk);
    `CHK(serr_cnt - s0, 1)
    apb(1'b0, APB_STAT, 32'h0, q, e);
    `CHK(q[STAT_QCNT_LSB +: 2], 2'h0)
    get(32'h0000_8000, CMD_IO_RD, 1'b0, 4, got, stp);
    `CHK(frames - f0, 2)
    retries <= 32'hFFFF_FFFF;
    s0 = serr_cnt;
    f0 = frames;
    ask(32'h0000_9000, CMD_IO_RD, 1'b0, k);
    @(posedge clk);
    irdy <= 0;
    repeat (60) @(posedge clk);
    ask(32'h0000_9000, CMD_IO_RD, 1'b0, k);
    `CHK(k, 1)
    `CHK(serr_cnt - s0, 1)
    `CHK(frames - f0, 4)
    rst();
    retries <= 0;
    pw <= 1;
    f0 = frames;
    for (i = 0; i < 6; i++) begin
      ask(32'h0000_A000 + 32'(16 * (i < 4 ? i % 2 : i - 2)), CMD_IO_RD, 1'b0, k);
      `CHK(k, 0)
      @(posedge clk);
      irdy <= 0;
      if (i == 3) begin
        apb(1'b0, APB_STAT, 32'h0, q, e);
        `CHK(q[STAT_QCNT_LSB +: 2], 2'h2)
      end
    end
    apb(1'b0, APB_STAT, 32'h0, q, e);
    `CHK(q[STAT_QCNT_LSB +: 2], 2'h3)
    `CHK(frames - f0, 0)
    pw <= 0;
    rst();
    $display("misc done");
  endtask
  initial begin
    rst();
    one(8'h08, 32'h0000_1004, CMD_IO_RD, CMD_IO_RD, 1'b0, 4'h5, 0, 1);
    one(8'h08, 32'h0000_1008, CMD_CFG_RD, CMD_CFG_RD, 1'b0, 4'h3, 1, 1);
    one(8'h08, 32'h0000_100C, CMD_MEM_RD, CMD_MEM_RD, 1'b0, 4'hA, 0, 1);
    one(8'h08, 32'h0000_1010, CMD_MEM_RD, CMD_MEM_RD_LINE, 1'b1, 4'h1, 2, 4);
    one(8'h08, 32'h0000_1100, CMD_MEM_RD_LINE, CMD_MEM_RD_MULT, 1'b1, 4'h0, 0, 8);
    one(8'h03, 32'h0000_3030, CMD_MEM_RD, CMD_MEM_RD, 1'b1, 4'h2, 0, 4);
    one(8'h02, 32'h0000_2000, CMD_MEM_RD_MULT, CMD_MEM_RD, 1'b1, 4'h0, 1, 4);
    one(8'h03, 32'h0000_5000, CMD_MEM_RD_MULT, CMD_MEM_RD_MULT, 1'b1, 4'h0, 0, 8);
    flow(32'h0000_4FD0, 20, 12);
    flow(32'h0000_7000, 3, 3);
    misc();
    close_out();
  end
  initial begin
    #200000;
    fail_count++;
    close_out();
  end
endmodule
